//--- pkg/cam_pkg.sv
/*
 package for the mailbox 0 acceptance mask block: register offsets,
 field positions, reset values and widths.
 assumes an apb slave with 32-bit data and word-aligned registers.
*/
`default_nettype none
package cam_pkg;
    localparam logic [7:0]  CAM_OFF_MASK_HIGH  = 8'h00;
    localparam logic [7:0]  CAM_OFF_MASK_LOW   = 8'h04;
    localparam logic [7:0]  CAM_OFF_MB0_ID     = 8'h08;
    localparam logic [7:0]  CAM_OFF_STATUS     = 8'h0C;
    localparam logic [15:0] CAM_RST_MASK_HIGH  = 16'h0000;
    localparam logic [15:0] CAM_RST_MASK_LOW   = 16'h0000;
    localparam logic [29:0] CAM_RST_MB0_ID     = 30'h00000000;
    // writable bits of the high mask: 15..13, 9..8, 7..0
    localparam logic [15:0] CAM_HIGH_WR_MASK   = 16'hE3FF;
    localparam int          CAM_BASE_BITS      = 11;
    localparam int          CAM_EXT_BITS       = 18;
    localparam int          CAM_ID_BITS        = 29;
    // mailbox 0 id register: [28:18] base, [17:0] extension, [29] format
    localparam int          CAM_ID_FMT_POS     = 29;
    localparam int          CAM_ST_ACCEPT_POS  = 0;
    localparam int          CAM_ST_COUNT_POS   = 16;
endpackage : cam_pkg
`default_nettype wire

//--- hw/cam_match.sv
/*
 per-bit masked compare of a received identifier against mailbox 0.
 assumes the caller registers the result; purely combinational.
*/
`timescale 1ns/1ns
`default_nettype none
module cam_match
    import cam_pkg::*;
#(
    parameter int W = 29
) (
    input  wire logic [W-1:0] rx_id,
    input  wire logic [W-1:0] ref_id,
    input  wire logic [W-1:0] mask,
    output logic              all_match
);
    logic [W-1:0] bit_ok;
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            // masked bit passes, else bit must equal stored id
            assign bit_ok[g] = mask[g] | (rx_id[g] == ref_id[g]);
        end
    endgenerate
    assign all_match = &bit_ok;
endmodule : cam_match
`default_nettype wire

//--- hw/cam_accept_mask.sv
/*
 acceptance mask registers and acceptance decision for receive mailbox 0.
 assumes an apb master on pclk and a receive engine that presents each
 received identifier with a one-cycle strobe on the same clock.
*/
// The implementer's own choices: register access over APB and the placing of the registers.
//
// Contract
// - eleven high-mask bits 15..13 and 7..0 mask the base identifier
// - high bits 9..8 and low bits 15..0 mask the 18 extension bits
// - mask bit 0: identifier bit must equal mailbox 0 identifier
// - mask bit 1: identifier bit is ignored for acceptance
// - all mask bits reset to zero, so all identifier bits used by the frame's format must match
// - high bits 12..10 read zero; software writes zero there
// - filtering applies only to mailbox 0, the receive-only mailbox
`timescale 1ns/1ns
`default_nettype none
module cam_accept_mask
    import cam_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_valid,
    input  wire logic [28:0] rx_id,
    input  wire logic        rx_ext,
    input  wire logic [3:0]  rx_mailbox,
    output logic             mb0_store,
    output logic [15:0]      accept_mask_high,
    output logic [15:0]      accept_mask_low
);
    logic [15:0] mask_high_ff;
    logic [15:0] nxt_mask_high;
    logic [15:0] mask_low_ff;
    logic [15:0] nxt_mask_low;
    logic [29:0] mb0_id_ff;
    logic [29:0] nxt_mb0_id;
    logic        store_ff;
    logic        nxt_store;
    logic [15:0] count_ff;
    logic [15:0] nxt_count;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic        err_ff;
    logic        nxt_err;
    logic        ready_ff;
    logic        nxt_ready;
    logic [28:0] full_mask;
    logic [28:0] eff_mask;
    logic        id_match;
    logic        fmt_ok;
    logic        acc;
    logic        setup;
    logic        access_done;
    logic        hit;

    assign setup       = psel & ~penable;
    assign access_done = psel & penable & ready_ff;
    assign hit = (paddr == CAM_OFF_MASK_HIGH) | (paddr == CAM_OFF_MASK_LOW)
               | (paddr == CAM_OFF_MB0_ID) | (paddr == CAM_OFF_STATUS);

    // base mask: high 7..0 on id 28..21, high 15..13 on id 20..18
    // extension mask: high 9..8 then low 15..0
    assign full_mask = {mask_high_ff[7:0], mask_high_ff[15:13],
                        mask_high_ff[9:8], mask_low_ff};
    // base frames: extension bits always pass
    assign eff_mask = rx_ext ? full_mask
                             : {full_mask[28:18], {CAM_EXT_BITS{1'b1}}};
    assign fmt_ok = (rx_ext == mb0_id_ff[CAM_ID_FMT_POS]);
    assign acc    = rx_valid & (rx_mailbox == 4'h0) & id_match & fmt_ok;

    cam_match #(.W(CAM_ID_BITS)) u_match (
        .rx_id     (rx_id),
        .ref_id    (mb0_id_ff[28:0]),
        .mask      (eff_mask),
        .all_match (id_match)
    );

    always_comb begin
        nxt_mask_high = mask_high_ff;
        nxt_mask_low  = mask_low_ff;
        nxt_mb0_id    = mb0_id_ff;
        nxt_ready     = 1'b0;
        nxt_rdata     = rdata_ff;
        nxt_err       = 1'b0;
        nxt_store     = acc;
        nxt_count     = count_ff + {15'h0000, acc};
        if (setup) begin
            nxt_ready = 1'b1;
            nxt_err   = ~hit;
            case (paddr)
                CAM_OFF_MASK_HIGH: nxt_rdata = {16'h0000, mask_high_ff};
                CAM_OFF_MASK_LOW:  nxt_rdata = {16'h0000, mask_low_ff};
                CAM_OFF_MB0_ID:    nxt_rdata = {2'h0, mb0_id_ff};
                CAM_OFF_STATUS:    nxt_rdata = {count_ff, 15'h0000, store_ff};
                default:           nxt_rdata = 32'h00000000;
            endcase
        end
        if (access_done & pwrite) begin
            case (paddr)
                CAM_OFF_MASK_HIGH:
                    nxt_mask_high = pwdata[15:0] & CAM_HIGH_WR_MASK;
                CAM_OFF_MASK_LOW:  nxt_mask_low = pwdata[15:0];
                CAM_OFF_MB0_ID:    nxt_mb0_id = pwdata[29:0];
                default:           nxt_mask_low = mask_low_ff;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_high_ff <= CAM_RST_MASK_HIGH;
            mask_low_ff  <= CAM_RST_MASK_LOW;
            mb0_id_ff    <= CAM_RST_MB0_ID;
            store_ff     <= 1'b0;
            count_ff     <= 16'h0000;
            rdata_ff     <= 32'h00000000;
            err_ff       <= 1'b0;
            ready_ff     <= 1'b0;
        end else begin
            mask_high_ff <= nxt_mask_high;
            mask_low_ff  <= nxt_mask_low;
            mb0_id_ff    <= nxt_mb0_id;
            store_ff     <= nxt_store;
            count_ff     <= nxt_count;
            rdata_ff     <= nxt_rdata;
            err_ff       <= nxt_err;
            ready_ff     <= nxt_ready;
        end
    end

    assign pready           = ready_ff;
    assign prdata           = rdata_ff;
    assign pslverr          = err_ff & ready_ff;
    assign mb0_store        = store_ff;
    assign accept_mask_high = mask_high_ff;
    assign accept_mask_low  = mask_low_ff;

    sequence s_hw;
        psel && penable && pready && pwrite && paddr == CAM_OFF_MASK_HIGH;
    endsequence

    sequence s_lw;
        psel && penable && pready && pwrite && paddr == CAM_OFF_MASK_LOW;
    endsequence

    sequence s_rx0_ext;
        rx_valid && rx_mailbox == 4'h0 && rx_ext
        && mb0_id_ff[CAM_ID_FMT_POS];
    endsequence

    sequence s_rx0_base;
        rx_valid && rx_mailbox == 4'h0 && !rx_ext
        && !mb0_id_ff[CAM_ID_FMT_POS];
    endsequence

    AST_RSV_ZERO: assert property (@(posedge pclk)
        disable iff (!presetn) mask_high_ff[12:10] == 3'h0)
        else $error("reserved high mask bits not zero");
    AST_RSV_READ: assert property (@(posedge pclk)
        disable iff (!presetn) pready && !pwrite
        && paddr == CAM_OFF_MASK_HIGH |-> prdata[12:10] == 3'h0)
        else $error("reserved high mask bits read non-zero");
    AST_HIGH_WRITE: assert property (@(posedge pclk)
        disable iff (!presetn)
        s_hw |=> mask_high_ff == ($past(pwdata[15:0]) & CAM_HIGH_WR_MASK))
        else $error("high mask write not stored");
    AST_LOW_WRITE: assert property (@(posedge pclk)
        disable iff (!presetn) s_lw |=> mask_low_ff == $past(pwdata[15:0]))
        else $error("low mask write not stored");
    AST_EXACT: assert property (@(posedge pclk)
        disable iff (!presetn) s_rx0_ext ##0 (full_mask == 29'h0)
        |=> mb0_store == ($past(rx_id) == $past(mb0_id_ff[28:0])))
        else $error("unmasked compare wrong");
    AST_EXT_REFUSE: assert property (@(posedge pclk)
        disable iff (!presetn)
        s_rx0_ext ##0 (((rx_id ^ mb0_id_ff[28:0]) & ~full_mask) != 29'h0)
        |=> !mb0_store)
        else $error("extended frame stored despite mismatch");
    AST_ALL_MASKED: assert property (@(posedge pclk)
        disable iff (!presetn) s_rx0_ext ##0 (full_mask == 29'h1FFFFFFF)
        |=> mb0_store)
        else $error("fully masked frame not stored");
    AST_EXT_PASS: assert property (@(posedge pclk)
        disable iff (!presetn)
        s_rx0_ext ##0 (((rx_id ^ mb0_id_ff[28:0]) & ~full_mask) == 29'h0)
        |=> mb0_store)
        else $error("masked extended frame not stored");
    AST_MB0_ONLY: assert property (@(posedge pclk)
        disable iff (!presetn) rx_mailbox != 4'h0 |=> !mb0_store)
        else $error("store for other mailbox");
    AST_FMT_REFUSE: assert property (@(posedge pclk)
        disable iff (!presetn)
        rx_valid && rx_ext != mb0_id_ff[CAM_ID_FMT_POS] |=> !mb0_store)
        else $error("frame of other format stored");
    AST_COUNT: assert property (@(posedge pclk)
        disable iff (!presetn)
        mb0_store |-> count_ff == $past(count_ff) + 16'h0001)
        else $error("accept count not advanced");
    AST_BASE: assert property (@(posedge pclk)
        disable iff (!presetn) s_rx0_base ##0 (full_mask[28:18] == 11'h0)
        |=> mb0_store == ($past(rx_id[28:18]) == $past(mb0_id_ff[28:18])))
        else $error("base frame compare wrong");
    AST_BASE_PASS: assert property (@(posedge pclk)
        disable iff (!presetn) s_rx0_base ##0
        (((rx_id[28:18] ^ mb0_id_ff[28:18]) & ~full_mask[28:18]) == 11'h0)
        |=> mb0_store)
        else $error("masked base frame not stored");
    AST_BASE_REFUSE: assert property (@(posedge pclk)
        disable iff (!presetn) s_rx0_base ##0
        (((rx_id[28:18] ^ mb0_id_ff[28:18]) & ~full_mask[28:18]) != 11'h0)
        |=> !mb0_store)
        else $error("base frame stored despite mismatch");
    AST_RESET: assert property (@(posedge pclk)
        $rose(presetn) |-> mask_high_ff == 16'h0000
        && mask_low_ff == 16'h0000)
        else $error("mask not zero after reset");
    AST_RESET_HOLD: assert property (@(posedge pclk)
        !presetn |-> mask_high_ff == 16'h0000
        && mask_low_ff == 16'h0000)
        else $error("mask not zero during reset");
endmodule : cam_accept_mask
`default_nettype wire

//--- verification/cam_rx_node.sv
/*
 receive engine stand-in: presents frames to the mailbox 0 filter.
 assumes the caller is aligned to a rising pclk edge.
*/
`timescale 1ns/1ns
`default_nettype none
module cam_rx_node (
    input  wire logic   pclk,
    output logic        rx_valid,
    output logic [28:0] rx_id,
    output logic        rx_ext,
    output logic [3:0]  rx_mailbox
);
    initial begin
        rx_valid = 1'b0;
        rx_id = '0;
        rx_ext = 1'b0;
        rx_mailbox = 4'h0;
    end
    // one-cycle strobe, then fields invert once released
    task automatic send(input logic [28:0] id, input logic e,
                        input logic [3:0] mb);
        rx_valid <= 1'b1;
        rx_id <= id;
        rx_ext <= e;
        rx_mailbox <= mb;
        @(posedge pclk);
        rx_valid <= 1'b0;
        rx_id <= ~id;
        rx_ext <= ~e;
        rx_mailbox <= ~mb;
    endtask : send
endmodule : cam_rx_node
`default_nettype wire

//--- verification/can_rx_acceptance_mask_bench.sv
/*
 self-checking bench for the mailbox 0 acceptance mask block.
 assumes pready ends each apb access and a store pulse follows rx by one
 cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module can_rx_acceptance_mask_bench;
    import cam_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        rx_valid, rx_ext, mb0_store, ref_fmt, e, exp_st;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [28:0] rx_id, ref_id, id;
    logic [3:0]  rx_mailbox, mb;
    logic [15:0] m_hi, m_lo, mh_o, ml_o;
    int          fail_count, n_tests, n_acc;
    cam_accept_mask i_cam_accept_mask (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_id(rx_id),
        .rx_ext(rx_ext), .rx_mailbox(rx_mailbox), .mb0_store(mb0_store),
        .accept_mask_high(mh_o), .accept_mask_low(ml_o));
    cam_rx_node i_cam_rx_node (.pclk(pclk), .rx_valid(rx_valid),
        .rx_id(rx_id), .rx_ext(rx_ext), .rx_mailbox(rx_mailbox));
    task automatic chk(input string s, input logic [31:0] x, y);
        n_tests++;
        if (x !== y) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", s, x, y);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        chk("pslverr", {31'h0, a > 8'h0C}, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    function automatic logic model(logic [28:0] i, logic x, logic [3:0] b);
        logic [28:0] dif;
        dif = (i ^ ref_id) & ~{m_hi[7:0], m_hi[15:13], m_hi[9:8], m_lo};
        if (!x) dif[17:0] = '0;
        return b == 4'h0 && x == ref_fmt && dif == '0;
    endfunction : model
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : close_out
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        #400000;
        fail_count++;
        close_out;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        fail_count = 0;
        n_tests = 0;
        n_acc = 0;
        void'($urandom(32'h730B));
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, CAM_OFF_MASK_HIGH, 32'h0);
        chk("mask_high", 32'h0, q);
        apb(1'b0, CAM_OFF_MASK_LOW, 32'h0);
        chk("mask_low", 32'h0, q);
        apb(1'b1, CAM_OFF_MASK_HIGH, 32'hFFFF);
        apb(1'b0, CAM_OFF_MASK_HIGH, 32'h0);
        chk("mask_high", 32'hE3FF, q);
        apb(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, q);
        $display("register test done");
        for (int t = 0; t < 60; t++) begin
            m_hi = (t < 5) ? 16'h0 : 16'($urandom) & CAM_HIGH_WR_MASK;
            m_lo = (t < 5) ? 16'h0 : 16'($urandom);
            ref_id = 29'($urandom);
            ref_fmt = 1'($urandom);
            if (t == 5) begin
                m_hi = CAM_HIGH_WR_MASK;
                m_lo = 16'hFFFF;
                ref_fmt = 1'b1;
            end
            apb(1'b1, CAM_OFF_MASK_HIGH, {16'h0, m_hi});
            apb(1'b1, CAM_OFF_MASK_LOW, {16'h0, m_lo});
            apb(1'b1, CAM_OFF_MB0_ID, {2'b0, ref_fmt, ref_id});
            apb(1'b0, CAM_OFF_MB0_ID, 32'h0);
            chk("mb0_id", {2'b0, ref_fmt, ref_id}, q);
            chk("accept_mask_high", {16'h0, m_hi}, {16'h0, mh_o});
            chk("accept_mask_low", {16'h0, m_lo}, {16'h0, ml_o});
            for (int k = 0; k < 8; k++) begin
                id = ref_id ^ (29'($urandom) & 29'($urandom) & 29'($urandom));
                e = ($urandom % 4 != 0) ? ref_fmt : ~ref_fmt;
                mb = ($urandom % 4 == 0) ? 4'h3 : 4'h0;
                exp_st = model(id, e, mb);
                n_acc = n_acc + exp_st;
                i_cam_rx_node.send(id, e, mb);
                @(posedge pclk);
                chk("mb0_store", {31'h0, exp_st},
                    {31'h0, mb0_store});
            end
        end
        $display("acceptance test done");
        apb(1'b0, CAM_OFF_STATUS, 32'h0);
        chk("accept_count", {16'(n_acc), 16'h0000}, q);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, CAM_OFF_MASK_HIGH, 32'h0);
        chk("mask_high", 32'h0, q);
        apb(1'b0, CAM_OFF_MASK_LOW, 32'h0);
        chk("mask_low", 32'h0, q);
        chk("accept_mask_high", 32'h0, {16'h0, mh_o});
        chk("accept_mask_low", 32'h0, {16'h0, ml_o});
        $display("reset test done");
        close_out;
    end
endmodule : can_rx_acceptance_mask_bench
`default_nettype wire
